// file: hdl/ecc_event_ctrl.sv
`timescale 1ns/1ps
`include "ecc_map.svh"

module ecc_event_ctrl #(
  parameter int unsigned SAMPLE_CYCLES = `ECC_CLK_HZ * `ECC_SAMPLE_S,
  parameter longint unsigned MINUTE_CYCLES = 64'(`ECC_CLK_HZ) * 64'(`ECC_MINUTE_S)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] solar_voltage,
  input wire logic [7:0] external_sense_voltage,
  input wire logic [7:0] temperature,
  input wire logic float_state,
  input wire logic night,
  input wire logic low_battery_cutoff,
  input wire logic push_button_input,
  output logic load_terminal_on,
  output logic aux_terminal_on,
  output logic event_on,
  output logic [2:0] status_digits
);

  logic [31:0] ctrl_ff, nxt_ctrl, sel_ff, nxt_sel, thr_ff, nxt_thr, time_ff, nxt_time;
  logic [31:0] prdata_ff, nxt_prdata, rd_data;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, setup, wr_en, mapped;
  logic sample_tick, minute_tick, tod_load;
  logic [7:0] tod;
  logic [2:0] program_select;
  ecc_pkg::ecc_code_type load_output_function, aux_output_function;
  logic [1:0] sense_input_config;
  ecc_pkg::ecc_code_type start_condition_select, stop_sel;
  ecc_pkg::ecc_code_type charge_state_qualifier_mode, auxiliary_qualifier_mode;
  logic [7:0] start_value, stop_value, temp_thr, external_sense_voltage_thr, time_thr;

  assign program_select = ctrl_ff[`ECC_CTRL_PROGRAM_SELECT_LSB +: 3];
  assign load_output_function = ctrl_ff[`ECC_CTRL_LOADFN_LSB +: 4];
  assign aux_output_function = ctrl_ff[`ECC_CTRL_AUXFN_LSB +: 4];
  assign sense_input_config = ctrl_ff[`ECC_CTRL_SENSE_LSB +: 2];
  assign start_condition_select = sel_ff[`ECC_SEL_START_LSB +: 4];
  assign stop_sel = sel_ff[`ECC_SEL_STOP_LSB +: 4];
  assign charge_state_qualifier_mode = sel_ff[`ECC_SEL_CSQ_LSB +: 4];
  assign auxiliary_qualifier_mode = sel_ff[`ECC_SEL_AUXQ_LSB +: 4];
  assign start_value = thr_ff[`ECC_THR_START_LSB +: 8];
  assign stop_value = thr_ff[`ECC_THR_STOP_LSB +: 8];
  assign temp_thr = thr_ff[`ECC_THR_TEMP_LSB +: 8];
  assign external_sense_voltage_thr = thr_ff[`ECC_THR_EXTERNAL_SENSE_VOLTAGE_LSB +: 8];
  assign time_thr = time_ff[`ECC_TIME_THR_LSB +: 8];

  ecc_timebase #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .MINUTE_CYCLES(MINUTE_CYCLES)
  ) u_timebase (
    .pclk(pclk),
    .presetn(presetn),
    .tod_load(tod_load),
    .tod_value(pwdata[7:0]),
    .sample_tick(sample_tick),
    .minute_tick(minute_tick),
    .time_of_day(tod)
  );

  // APB slave: the setup cycle prepares the answer, the access cycle carries it.
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign tod_load = wr_en && (paddr == `ECC_REG_CLOCK);

  logic [31:0] status_word;
  ecc_pkg::ecc_event_type ev_ff, nxt_ev;
  logic [2:0] digits_ff, nxt_digits;
  logic load_ff, nxt_load, aux_ff, nxt_aux;

  assign status_word = {24'h0, 2'b00, aux_ff, load_ff, digits_ff, ev_ff == ecc_pkg::ecc_ev_on};

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      `ECC_REG_CTRL: rd_data = ctrl_ff;
      `ECC_REG_SEL: rd_data = sel_ff;
      `ECC_REG_THR: rd_data = thr_ff;
      `ECC_REG_TIME: rd_data = time_ff;
      `ECC_REG_CLOCK: rd_data = {24'h0, tod};
      `ECC_REG_STATUS: rd_data = status_word;
      default: begin
        rd_data = 32'h0;
        mapped = 1'b0;
      end
    endcase
    nxt_pready = setup;
    nxt_prdata = (setup && !pwrite && mapped) ? rd_data : 32'h0;
    nxt_pslverr = setup && (!mapped || (pwrite && paddr == `ECC_REG_STATUS));
    nxt_ctrl = ctrl_ff;
    nxt_sel = sel_ff;
    nxt_thr = thr_ff;
    nxt_time = time_ff;
    if (wr_en) begin
      unique case (paddr)
        `ECC_REG_CTRL: nxt_ctrl = {18'h0, pwdata[13:8], pwdata[7:4], 1'b0, pwdata[2:0]};
        `ECC_REG_SEL: nxt_sel = {16'h0, pwdata[15:0]};
        `ECC_REG_THR: nxt_thr = pwdata;
        `ECC_REG_TIME: nxt_time = {24'h0, pwdata[7:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `ECC_RST_CTRL;
      sel_ff <= `ECC_RST_SEL;
      thr_ff <= `ECC_RST_THR;
      time_ff <= `ECC_RST_TIME;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      sel_ff <= nxt_sel;
      thr_ff <= nxt_thr;
      time_ff <= nxt_time;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // The push-button pin is asynchronous; a change counts once stages two and three agree.
  logic pb_s1_ff, pb_s2_ff, pb_s3_ff, pb_ff, nxt_pb;

  always_comb begin
    nxt_pb = (pb_s2_ff == pb_s3_ff) ? pb_s3_ff : pb_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_s1_ff <= 1'b0;
      pb_s2_ff <= 1'b0;
      pb_s3_ff <= 1'b0;
      pb_ff <= 1'b0;
    end else begin
      pb_s1_ff <= push_button_input;
      pb_s2_ff <= pb_s1_ff;
      pb_s3_ff <= pb_s2_ff;
      pb_ff <= nxt_pb;
    end
  end

  // Repeat-interval length in minutes; zero means the interval never expires.
  function automatic ecc_pkg::ecc_minutes_type interval_min(input logic is_start,
                                                            input ecc_pkg::ecc_code_type code,
                                                            input logic [7:0] value);
    interval_min = 11'h0;
    unique case (code)
      4'h8: interval_min = is_start ? 11'h00a : 11'h001;
      4'h9: interval_min = is_start ? 11'h01e : 11'h003;
      4'ha: interval_min = is_start ? 11'h03c : 11'h006;
      4'hb: interval_min = is_start ? 11'h078 : 11'h00c;
      4'he: interval_min = is_start ? 11'(value) : 11'h0;
      4'hf: interval_min = is_start ? 11'(value) * 11'h006 : 11'h0;
      default: interval_min = 11'h0;
    endcase
  endfunction : interval_min

  logic sense_ok, pb_on, start_cond, stop_cond, cs_act, aux_act;
  logic start_go, stop_go, start_fire, stop_fire, lbd_overrides;
  ecc_pkg::ecc_minutes_type start_iv, stop_iv;
  ecc_pkg::ecc_minutes_type start_el_ff, nxt_start_el, stop_el_ff, nxt_stop_el;
  ecc_pkg::ecc_minutes_type run_ff, nxt_run;
  logic start_pend_ff, nxt_start_pend, stop_pend_ff, nxt_stop_pend;

  always_comb begin
    sense_ok = (sense_input_config == `ECC_SENSE_EXT);
    pb_on = sense_ok && pb_ff;
    start_iv = interval_min(1'b1, start_condition_select, start_value);
    stop_iv = interval_min(1'b0, stop_sel, stop_value);
    start_fire = minute_tick && (start_iv != 11'h0) && (start_el_ff + 11'h1 >= start_iv);
    stop_fire = minute_tick && (stop_iv != 11'h0) && (stop_el_ff + 11'h1 >= stop_iv);
    nxt_start_el = start_fire ? 11'h0 : (minute_tick ? start_el_ff + 11'h1 : start_el_ff);
    nxt_stop_el = stop_fire ? 11'h0 : (minute_tick ? stop_el_ff + 11'h1 : stop_el_ff);
    // A fresh expiry in the sampling cycle survives the consuming clear.
    nxt_start_pend = start_fire || (start_pend_ff && !sample_tick);
    nxt_stop_pend = stop_fire || (stop_pend_ff && !sample_tick);

    unique case (start_condition_select)
      4'h0: start_cond = solar_voltage > start_value;
      4'h1: start_cond = solar_voltage < start_value;
      4'h2: start_cond = sense_ok && (external_sense_voltage > start_value);
      4'h3: start_cond = sense_ok && (external_sense_voltage < start_value);
      4'h4: start_cond = pb_on && (tod > start_value);
      4'h5: start_cond = sense_ok && !pb_ff && (tod > start_value);
      4'h8, 4'h9, 4'ha, 4'hb: start_cond = start_pend_ff && (tod > start_value);
      4'hc: start_cond = tod > start_value;
      4'he, 4'hf: start_cond = start_pend_ff;
      default: start_cond = 1'b0;
    endcase

    unique case (stop_sel)
      4'h0: stop_cond = solar_voltage > stop_value;
      4'h1: stop_cond = solar_voltage < stop_value;
      4'h2: stop_cond = sense_ok && (external_sense_voltage > stop_value);
      4'h3: stop_cond = sense_ok && (external_sense_voltage < stop_value);
      4'h4: stop_cond = sense_ok && !pb_ff && (tod > stop_value);
      4'h5: stop_cond = pb_on && (tod > stop_value);
      4'h8, 4'h9, 4'ha, 4'hb: stop_cond = stop_pend_ff && (tod > stop_value);
      // A time threshold above 23.9 is never passed because the clock wraps.
      4'hc: stop_cond = tod > stop_value;
      4'he: stop_cond = run_ff >= 11'(stop_value);
      4'hf: stop_cond = run_ff >= 11'(stop_value) * 11'h006;
      default: stop_cond = 1'b0;
    endcase

    unique case (charge_state_qualifier_mode)
      4'h0: cs_act = 1'b1;
      4'h1: cs_act = float_state;
      4'h2: cs_act = night;
      4'h3: cs_act = !night;
      4'h5: cs_act = float_state && night;
      4'h6: cs_act = float_state && !night;
      default: cs_act = 1'b0;
    endcase

    // Sense voltage threshold and input share the offset code, so plain compare works.
    unique case (auxiliary_qualifier_mode)
      4'h0, 4'h8: aux_act = 1'b1;
      4'h1, 4'h9: aux_act = $signed(temperature) > $signed(temp_thr);
      4'h2, 4'ha: aux_act = $signed(temperature) < $signed(temp_thr);
      4'h3, 4'hb: aux_act = sense_ok && (external_sense_voltage > external_sense_voltage_thr);
      4'h4, 4'hc: aux_act = sense_ok && (external_sense_voltage < external_sense_voltage_thr);
      4'h5, 4'hd: aux_act = tod > time_thr;
      4'h6, 4'he: aux_act = tod < time_thr;
      default: aux_act = 1'b0;
    endcase

    start_go = start_cond && cs_act && aux_act;
    stop_go = stop_cond || !cs_act || !aux_act;
    lbd_overrides = auxiliary_qualifier_mode < `ECC_AUXQ_NO_LBD;
  end

  // Event flag, status digits and terminal drives.
  always_comb begin
    nxt_ev = ev_ff;
    nxt_digits = digits_ff;
    nxt_run = run_ff;
    if (minute_tick && ev_ff == ecc_pkg::ecc_ev_on && run_ff != 11'h7ff) begin
      nxt_run = run_ff + 11'h1;
    end
    if (program_select != `ECC_PROGRAM_SELECT_EVENT) begin
      nxt_ev = ecc_pkg::ecc_ev_off;
    end else if (sample_tick) begin
      unique case (ev_ff)
        ecc_pkg::ecc_ev_off: if (start_go) begin
          nxt_ev = ecc_pkg::ecc_ev_on;
          nxt_run = 11'h0;
        end
        ecc_pkg::ecc_ev_on: if (stop_go) begin
          nxt_ev = ecc_pkg::ecc_ev_off;
        end
      endcase
    end
    if (sample_tick) begin
      nxt_digits[2] = (ev_ff == ecc_pkg::ecc_ev_on) ? stop_cond : start_cond;
      nxt_digits[1] = cs_act;
      nxt_digits[0] = aux_act;
    end
    nxt_load = (ev_ff == ecc_pkg::ecc_ev_on) && (!lbd_overrides || !low_battery_cutoff) &&
               (load_output_function == `ECC_FN_EVENT ||
                load_output_function == `ECC_FN_EVENT_ALT);
    nxt_aux = (ev_ff == ecc_pkg::ecc_ev_on) && (!lbd_overrides || !low_battery_cutoff) &&
              (aux_output_function == `ECC_FN_EVENT ||
               aux_output_function == `ECC_FN_EVENT_ALT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_ff <= ecc_pkg::ecc_ev_off;
      digits_ff <= 3'h0;
      load_ff <= 1'b0;
      aux_ff <= 1'b0;
      run_ff <= 11'h0;
      start_el_ff <= 11'h0;
      stop_el_ff <= 11'h0;
      start_pend_ff <= 1'b0;
      stop_pend_ff <= 1'b0;
    end else begin
      ev_ff <= nxt_ev;
      digits_ff <= nxt_digits;
      load_ff <= nxt_load;
      aux_ff <= nxt_aux;
      run_ff <= nxt_run;
      start_el_ff <= nxt_start_el;
      stop_el_ff <= nxt_stop_el;
      start_pend_ff <= nxt_start_pend;
      stop_pend_ff <= nxt_stop_pend;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign load_terminal_on = load_ff;
  assign aux_terminal_on = aux_ff;
  assign event_on = (ev_ff == ecc_pkg::ecc_ev_on);
  assign status_digits = digits_ff;

endmodule : ecc_event_ctrl

// file: hdl/ecc_map.svh
`ifndef ECC_MAP_SVH
`define ECC_MAP_SVH

// Register byte offsets.
`define ECC_REG_CTRL 8'h00
`define ECC_REG_SEL 8'h04
`define ECC_REG_THR 8'h08
`define ECC_REG_TIME 8'h0c
`define ECC_REG_CLOCK 8'h10
`define ECC_REG_STATUS 8'h14

// Field positions.
`define ECC_CTRL_PROGRAM_SELECT_LSB 0
`define ECC_CTRL_LOADFN_LSB 4
`define ECC_CTRL_AUXFN_LSB 8
`define ECC_CTRL_SENSE_LSB 12
`define ECC_SEL_START_LSB 0
`define ECC_SEL_STOP_LSB 4
`define ECC_SEL_CSQ_LSB 8
`define ECC_SEL_AUXQ_LSB 12
`define ECC_THR_START_LSB 0
`define ECC_THR_STOP_LSB 8
`define ECC_THR_TEMP_LSB 16
`define ECC_THR_EXTERNAL_SENSE_VOLTAGE_LSB 24
`define ECC_TIME_THR_LSB 0

// Reset values.
`define ECC_RST_CTRL 32'h0000_0000
`define ECC_RST_SEL 32'h0000_0000
`define ECC_RST_THR 32'h5000_0000
`define ECC_RST_TIME 32'h0000_0000

// Codes and encodings.
`define ECC_PROGRAM_SELECT_EVENT 3'h4
`define ECC_FN_EVENT 4'h4
`define ECC_FN_EVENT_ALT 4'h5
`define ECC_SENSE_EXT 2'h2
`define ECC_EXTERNAL_SENSE_VOLTAGE_ZERO 8'h50
`define ECC_AUXQ_NO_LBD 4'h8
`define ECC_TOD_LAST 8'hef
`define ECC_TOD_STEP_MIN 3'h6

// Timing: sampling interval and minute, in seconds, at a 40 MHz clock.
`define ECC_CLK_HZ 40000000
`define ECC_SAMPLE_S 1
`define ECC_MINUTE_S 60

`endif

// file: hdl/ecc_pkg.sv
package ecc_pkg;

  typedef enum logic {
    ecc_ev_off,
    ecc_ev_on
  } ecc_event_type;

  typedef logic [3:0] ecc_code_type;
  typedef logic [10:0] ecc_minutes_type;

endpackage : ecc_pkg

// file: hdl/ecc_timebase.sv
`timescale 1ns/1ps
`include "ecc_map.svh"

// Sampling tick, minute tick and the time-of-day counter in tenths of an hour.
module ecc_timebase #(
  parameter int unsigned SAMPLE_CYCLES = `ECC_CLK_HZ * `ECC_SAMPLE_S,
  parameter longint unsigned MINUTE_CYCLES = 64'(`ECC_CLK_HZ) * 64'(`ECC_MINUTE_S)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tod_load,
  input wire logic [7:0] tod_value,
  output logic sample_tick,
  output logic minute_tick,
  output logic [7:0] time_of_day
);

  logic [31:0] samp_cnt_ff, nxt_samp_cnt;
  logic [31:0] min_cnt_ff, nxt_min_cnt;
  logic [2:0] step_ff, nxt_step;
  logic [7:0] tod_ff, nxt_tod;
  logic samp_ff, nxt_samp, min_ff, nxt_min;

  always_comb begin
    nxt_samp = (samp_cnt_ff == 32'(SAMPLE_CYCLES - 1));
    nxt_samp_cnt = nxt_samp ? 32'h0 : samp_cnt_ff + 32'h1;
    nxt_min = (min_cnt_ff == 32'(MINUTE_CYCLES - 1));
    nxt_min_cnt = nxt_min ? 32'h0 : min_cnt_ff + 32'h1;
    nxt_step = step_ff;
    nxt_tod = tod_ff;
    if (tod_load) begin
      nxt_step = 3'h0;
      nxt_tod = (tod_value > `ECC_TOD_LAST) ? 8'h0 : tod_value;
    end else if (min_ff) begin
      if (step_ff == `ECC_TOD_STEP_MIN - 3'h1) begin
        nxt_step = 3'h0;
        // Midnight wrap keeps every time-of-day value below 24.0 hours.
        nxt_tod = (tod_ff == `ECC_TOD_LAST) ? 8'h0 : tod_ff + 8'h1;
      end else begin
        nxt_step = step_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_cnt_ff <= 32'h0;
      min_cnt_ff <= 32'h0;
      step_ff <= 3'h0;
      tod_ff <= 8'h0;
      samp_ff <= 1'b0;
      min_ff <= 1'b0;
    end else begin
      samp_cnt_ff <= nxt_samp_cnt;
      min_cnt_ff <= nxt_min_cnt;
      step_ff <= nxt_step;
      tod_ff <= nxt_tod;
      samp_ff <= nxt_samp;
      min_ff <= nxt_min;
    end
  end

  assign sample_tick = samp_ff;
  assign minute_tick = min_ff;
  assign time_of_day = tod_ff;

endmodule : ecc_timebase

// file: tb/ecc_event_ctrl_asserts.sv
`timescale 1ns/1ps
module ecc_event_ctrl_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic low_battery_cutoff,
  input wire logic load_terminal_on,
  input wire logic aux_terminal_on,
  input wire logic event_on,
  input wire logic [2:0] status_digits
);
  // Shadows of the control and selection words, rebuilt from bus writes.
  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl;
  logic [15:0] sel_ff;
  logic [15:0] nxt_sel;
  logic prog4;
  logic gate;
  logic lo_cause;
  logic au_cause;
  logic mapped;
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_sel = sel_ff;
    if (psel && penable && pready && pwrite && paddr == 8'h00)
      nxt_ctrl = pwdata[15:0];
    if (psel && penable && pready && pwrite && paddr == 8'h04)
      nxt_sel = pwdata[15:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 16'h0000;
      sel_ff <= 16'h0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      sel_ff <= nxt_sel;
    end
  end
  assign prog4 = ctrl_ff[2:0] == 3'h4;
  assign gate = low_battery_cutoff && sel_ff[15:12] < 4'h8;
  // Function codes 4 and 5 share the pattern 010x, so one compare covers both.
  assign lo_cause = event_on && prog4 && !gate && ctrl_ff[7:5] == 3'h2;
  assign au_cause = event_on && prog4 && !gate && ctrl_ff[11:9] == 3'h2;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= 8'h14;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rise_held;
    $rose(event_on) ##1 prog4 [*2];
  endsequence
  property p_pready_once;
    s_setup |=> pready ##1 !pready;
  endproperty
  property p_unmapped;
    s_setup ##0 !mapped |=> pslverr && prdata == 32'h0;
  endproperty
  property p_status_read;
    s_setup ##0 (!pwrite && paddr == 8'h14) |=>
      prdata[3:0] == {$past(status_digits), $past(event_on)};
  endproperty
  property p_program_select_off;
    !prog4 [*2] |-> !event_on;
  endproperty
  property p_load_follow;
    load_terminal_on |-> $past(event_on);
  endproperty
  property p_load_on;
    $past(lo_cause) |-> load_terminal_on;
  endproperty
  property p_aux_on;
    $past(au_cause) |-> aux_terminal_on;
  endproperty
  property p_lbd;
    gate |=> !load_terminal_on && !aux_terminal_on;
  endproperty
  property p_rise;
    $rose(event_on) |-> status_digits[1:0] == 2'h3;
  endproperty
  property p_spacing;
    s_rise_held |-> $stable(event_on) && $past(event_on);
  endproperty
  a_pready_once: assert property (p_pready_once)
    else $error("pready is not a single access cycle");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  a_status_read: assert property (p_status_read)
    else $error("status read does not match the event flag and digits");
  a_program_select_off: assert property (p_program_select_off)
    else $error("event active without program select 4");
  a_load_follow: assert property (p_load_follow)
    else $error("load terminal on without the event");
  a_load_on: assert property (p_load_on)
    else $error("load terminal missed an active event");
  a_aux_on: assert property (p_aux_on)
    else $error("aux terminal missed an active event");
  a_lbd: assert property (p_lbd)
    else $error("low battery did not switch the terminals off");
  a_rise: assert property (p_rise)
    else $error("event started with a qualifier inactive");
  a_spacing: assert property (p_spacing)
    else $error("event changed between sample ticks");
endmodule : ecc_event_ctrl_asserts

bind ecc_event_ctrl ecc_event_ctrl_asserts u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .low_battery_cutoff(low_battery_cutoff), .load_terminal_on(load_terminal_on),
  .aux_terminal_on(aux_terminal_on), .event_on(event_on), .status_digits(status_digits)
);

// file: tb/ecc_load_model.sv
`timescale 1ns/1ps
// A load or relay on a terminal; a larger delay models a slow relay coil.
module ecc_load_model #(
  parameter int DELAY = 0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic terminal_on,
  output logic energized
);
  logic [7:0] hist_ff;
  logic [7:0] nxt_hist;
  always_comb begin
    nxt_hist = {hist_ff[6:0], terminal_on};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hist_ff <= 8'h00;
    else
      hist_ff <= nxt_hist;
  end
  assign energized = hist_ff[DELAY];
endmodule : ecc_load_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "ecc_map.svh"
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] solar_voltage = 8'h00;
  logic [7:0] external_sense_voltage = 8'h50;
  logic signed [7:0] temperature = 8'sh00;
  logic float_state = 1'b0;
  logic night = 1'b0;
  logic low_battery_cutoff = 1'b0;
  logic push_button_input = 1'b0;
  logic load_terminal_on;
  logic aux_terminal_on;
  logic event_on;
  logic [2:0] status_digits;
  logic ld_en;
  logic ax_en;
  logic [31:0] seed = 32'h0000_0055;
  int fails = 0;
  int checks_done = 0;

  always #12.5 pclk = ~pclk;

  ecc_event_ctrl #(.SAMPLE_CYCLES(4), .MINUTE_CYCLES(16)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .solar_voltage(solar_voltage), .external_sense_voltage(external_sense_voltage),
    .temperature(temperature), .float_state(float_state), .night(night),
    .low_battery_cutoff(low_battery_cutoff), .push_button_input(push_button_input),
    .load_terminal_on(load_terminal_on), .aux_terminal_on(aux_terminal_on),
    .event_on(event_on), .status_digits(status_digits)
  );
  ecc_load_model #(.DELAY(0)) u_load (.pclk(pclk), .presetn(presetn),
    .terminal_on(load_terminal_on), .energized(ld_en));
  ecc_load_model #(.DELAY(3)) u_relay (.pclk(pclk), .presetn(presetn),
    .terminal_on(aux_terminal_on), .energized(ax_en));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic cs_exp(input logic [3:0] c, input logic f, input logic n);
    case (c)
      4'h0: return 1'b1;
      4'h1: return f;
      4'h2: return n;
      4'h3: return !n;
      4'h5: return f && n;
      4'h6: return f && !n;
      default: return 1'b0;
    endcase
  endfunction : cs_exp

  function automatic logic aux_exp(input logic [3:0] c, input logic signed [7:0] t,
                                   input logic signed [7:0] tt, input logic [7:0] v,
                                   input logic [7:0] vt, input logic [7:0] h,
                                   input logic [7:0] ht);
    case (c[2:0])
      3'h0: return 1'b1;
      3'h1: return t > tt;
      3'h2: return t < tt;
      3'h3: return v > vt;
      3'h4: return v < vt;
      3'h5: return h > ht;
      3'h6: return h < ht;
      default: return 1'b0;
    endcase
  endfunction : aux_exp

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp,
                     input logic eexp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, exp, r);
    chk("pslverr", 32'(eexp), 32'(e));
  endtask : rdc

  task automatic press();
    push_button_input <= 1'b1;
    repeat (12) @(posedge pclk);
    push_button_input <= 1'b0;
  endtask : press

  task automatic test_done();
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  initial begin
    #(25 * 40000);
    fails++;
    test_done();
  end

  initial begin
    logic [31:0] x;
    logic [31:0] y;
    logic e;
    logic [3:0] cm;
    logic [3:0] am;
    logic [7:0] h;
    logic [7:0] ht;
    logic ev;
    logic ld;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("ctrl", `ECC_REG_CTRL, `ECC_RST_CTRL, 1'b0);
    rdc("sel", `ECC_REG_SEL, `ECC_RST_SEL, 1'b0);
    rdc("thr", `ECC_REG_THR, `ECC_RST_THR, 1'b0);
    rdc("time", `ECC_REG_TIME, `ECC_RST_TIME, 1'b0);
    // Both qualifier modes are zero, so digits one and zero read one from the first tick.
    rdc("status", `ECC_REG_STATUS, 32'h0000_0006, 1'b0);
    rdc("unmapped", 8'h18, 32'h0, 1'b1);
    apb(1'b1, `ECC_REG_STATUS, 32'h3f, x, e);
    chk("status_write", 32'h1, 32'(e));
    wr(`ECC_REG_CLOCK, 32'hef);
    x = 32'hef;
    for (int i = 0; i < 40 && x == 32'hef; i++) begin
      repeat (6) @(posedge pclk);
      apb(1'b0, `ECC_REG_CLOCK, 32'h0, x, e);
    end
    chk("tod_wrap", 32'h0, x);
    for (int i = 0; i < 30; i++) begin
      cm = 4'(i % 7);
      am = 4'(i % 15);
      x = rnd();
      y = rnd();
      h = 8'(y[7:0] % 200 + 1);
      ht = y[15:8];
      if (ht == h || ht == h + 8'h1)
        ht = h + 8'h3;
      wr(`ECC_REG_CTRL, 32'h0000_2544);
      wr(`ECC_REG_SEL, {16'h0, am, cm, 8'hcc});
      wr(`ECC_REG_THR, {x[31:16], 16'hfa00});
      wr(`ECC_REG_TIME, {24'h0, ht});
      wr(`ECC_REG_CLOCK, {24'h0, h});
      temperature <= x[7:0];
      external_sense_voltage <= x[15:8];
      float_state <= y[16];
      night <= y[17];
      low_battery_cutoff <= y[18];
      solar_voltage <= y[31:24];
      repeat (16) @(posedge pclk);
      ev = cs_exp(cm, float_state, night) &&
           aux_exp(am, temperature, x[23:16], external_sense_voltage, x[31:24], h, ht);
      ld = ev && !(low_battery_cutoff && am < 4'h8);
      chk("outputs", 32'({ev, !ev, cs_exp(cm, float_state, night),
          aux_exp(am, temperature, x[23:16], external_sense_voltage, x[31:24], h, ht),
          ld, ld, ld, ld}), 32'({event_on, status_digits, load_terminal_on,
          aux_terminal_on, ld_en, ax_en}));
    end
    low_battery_cutoff <= 1'b0;
    wr(`ECC_REG_SEL, 32'h0000_00cc);
    wr(`ECC_REG_CTRL, 32'h0000_2543);
    repeat (10) @(posedge pclk);
    chk("prog3", 32'h0, 32'({event_on, load_terminal_on, aux_terminal_on}));
    wr(`ECC_REG_CTRL, 32'h0000_2544);
    repeat (12) @(posedge pclk);
    chk("prog4", 32'h7, 32'({event_on, load_terminal_on, aux_terminal_on}));
    wr(`ECC_REG_THR, 32'h5000_0200);
    wr(`ECC_REG_SEL, 32'h0000_00e4);
    wr(`ECC_REG_CTRL, 32'h0000_0544);
    repeat (60) @(posedge pclk);
    chk("run_end", 32'h0, 32'(event_on));
    press();
    repeat (6) @(posedge pclk);
    chk("pb_no_sense", 32'h0, 32'(event_on));
    wr(`ECC_REG_CTRL, 32'h0000_2544);
    press();
    chk("pb_start", 32'h1, 32'(event_on));
    repeat (50) @(posedge pclk);
    chk("run_stop", 32'h0, 32'(event_on));
    wr(`ECC_REG_THR, 32'h5000_fa01);
    wr(`ECC_REG_SEL, 32'h0000_00ce);
    repeat (24) @(posedge pclk);
    chk("repeat_start", 32'h1, 32'(event_on));
    test_done();
  end
endmodule : tb_top
